// File: common/adc_cap_pkg.sv
// Package: register map, field layout and timing constants for the converter control block
package adc_cap_pkg;
    localparam int NUM_SEQ = 4;
    localparam int NUM_CMP = 8;
    localparam int RES_W = 12;
    localparam int ADDR_W = 8;

    // Register offsets (byte addresses)
    localparam logic [7:0] REG_SEQ_RAW = 8'h00;
    localparam logic [7:0] REG_SEQ_MASK = 8'h04;
    localparam logic [7:0] REG_SEQ_STAT = 8'h08;
    localparam logic [7:0] REG_SEQ_CLR = 8'h0C;
    localparam logic [7:0] REG_CMP_STAT = 8'h10;
    localparam logic [7:0] REG_CMP_SEQEN = 8'h14;
    localparam logic [7:0] REG_AVG = 8'h18;
    localparam logic [7:0] REG_PHASE = 8'h1C;
    localparam logic [7:0] REG_CMP_RESET = 8'h20;
    localparam logic [7:0] REG_CMP_CFG = 8'h40;
    localparam logic [7:0] REG_CMP_BAND = 8'h60;

    // Comparator configuration fields
    localparam int CFG_TRIG_LSB = 0;
    localparam int CFG_INT_LSB = 4;
    localparam int CFG_W = 4;
    localparam int BAND_LOW_LSB = 0;
    localparam int BAND_HIGH_LSB = 16;
    localparam int RST_INT_LSB = 8;
    localparam int STAT_MASKED_LSB = 4;

    // Mode field: bit 3 hysteresis, bit 2 once, bits 1:0 band select
    localparam logic [1:0] BSEL_LOW = 2'h0;
    localparam logic [1:0] BSEL_MID = 2'h1;
    localparam logic [1:0] BSEL_HIGH = 2'h2;
    localparam logic [1:0] BSEL_NONE = 2'h3;

    localparam logic [31:0] CFG_RESET = 32'h0000_0033;
    localparam logic [31:0] BAND_RESET = 32'h0FFF_0000;
    localparam logic [2:0] AVG_MAX = 3'h6;
    localparam int PHASE_STEPS = 16;
    localparam logic [3:0] PHASE_RESET = 4'h0;

    // Conversion period and derived phase step in cycles
    localparam int CONV_PERIOD_NS = 1024;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_CYCLES = CONV_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PHASE_STEP_CYCLES = CONV_CYCLES / PHASE_STEPS;

    typedef enum logic [1:0] {
        BAND_LO,
        BAND_MD,
        BAND_HI
    } band_t;
endpackage

// File: design/adc_cmp_unit.sv
// Digital comparator: band classification, history and trigger/interrupt firing
`timescale 1ns/10ps
module adc_cmp_unit
    import adc_cap_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic valid_i,
    input wire logic [RES_W-1:0] result_i,
    input wire logic [RES_W-1:0] low_band_threshold_i,
    input wire logic [RES_W-1:0] high_band_threshold_i,
    input wire logic [CFG_W-1:0] trig_mode_i,
    input wire logic [CFG_W-1:0] int_mode_i,
    input wire logic clear_trigger_history_i,
    input wire logic clear_interrupt_history_i,
    output logic trig_fire_o,
    output logic int_fire_o
);
    band_t band_now;
    logic t_prev_ok_q, t_prev_ok_d, i_prev_ok_q, i_prev_ok_d;
    band_t t_prev_q, t_prev_d, i_prev_q, i_prev_d;
    logic t_arm_q, t_arm_d, i_arm_q, i_arm_d;
    logic t_fire, i_fire;

    function automatic band_t classify(input logic [RES_W-1:0] v,
                                       input logic [RES_W-1:0] lo,
                                       input logic [RES_W-1:0] hi);
        if (v <= lo) begin
            return BAND_LO;
        end else if (v <= hi) begin
            return BAND_MD;
        end
        return BAND_HI;
    endfunction

    // Decide firing from mode, current band, previous band and hysteresis arm
    function automatic logic fires(input logic [CFG_W-1:0] m, input band_t b,
                                   input band_t p, input logic p_ok, input logic arm);
        logic hit;
        logic entry;
        hit = 1'b0;
        entry = 1'b0;
        unique case (m[1:0])
            BSEL_LOW: hit = (b == BAND_LO);
            BSEL_MID: hit = (b == BAND_MD) && !m[3];
            BSEL_HIGH: hit = (b == BAND_HI);
            BSEL_NONE: hit = 1'b0;
        endcase
        entry = !p_ok || (p != b);
        if (m[3] && !arm) begin
            hit = 1'b0;
        end
        if (m[2] && !entry && !m[3]) begin
            hit = 1'b0;
        end
        return hit;
    endfunction

    // Arm after visiting the opposite extreme; disarm after firing
    function automatic logic next_arm(input logic [CFG_W-1:0] m, input band_t b,
                                      input logic arm, input logic fired);
        logic a;
        a = arm;
        if (fired && m[3]) begin
            a = 1'b0;
        end
        if ((m[1:0] == BSEL_LOW && b == BAND_HI) || (m[1:0] == BSEL_HIGH && b == BAND_LO)) begin
            a = 1'b1;
        end
        return a;
    endfunction

    always_comb begin
        band_now = classify(result_i, low_band_threshold_i, high_band_threshold_i);
        t_fire = valid_i && fires(trig_mode_i, band_now, t_prev_q, t_prev_ok_q, t_arm_q);
        i_fire = valid_i && fires(int_mode_i, band_now, i_prev_q, i_prev_ok_q, i_arm_q);
        t_prev_d = t_prev_q;
        t_prev_ok_d = t_prev_ok_q;
        t_arm_d = t_arm_q;
        i_prev_d = i_prev_q;
        i_prev_ok_d = i_prev_ok_q;
        i_arm_d = i_arm_q;
        if (valid_i) begin
            t_prev_d = band_now;
            t_prev_ok_d = 1'b1;
            t_arm_d = next_arm(trig_mode_i, band_now, t_arm_q, t_fire);
            i_prev_d = band_now;
            i_prev_ok_d = 1'b1;
            i_arm_d = next_arm(int_mode_i, band_now, i_arm_q, i_fire);
        end
        if (clear_trigger_history_i) begin
            t_prev_d = BAND_MD;
            t_prev_ok_d = 1'b0;
            t_arm_d = 1'b0;
        end
        if (clear_interrupt_history_i) begin
            i_prev_d = BAND_MD;
            i_prev_ok_d = 1'b0;
            i_arm_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t_prev_q <= BAND_MD;
            t_prev_ok_q <= 1'b0;
            t_arm_q <= 1'b0;
            i_prev_q <= BAND_MD;
            i_prev_ok_q <= 1'b0;
            i_arm_q <= 1'b0;
            trig_fire_o <= 1'b0;
            int_fire_o <= 1'b0;
        end else begin
            t_prev_q <= t_prev_d;
            t_prev_ok_q <= t_prev_ok_d;
            t_arm_q <= t_arm_d;
            i_prev_q <= i_prev_d;
            i_prev_ok_q <= i_prev_ok_d;
            i_arm_q <= i_arm_d;
            trig_fire_o <= t_fire;
            int_fire_o <= i_fire;
        end
    end

    a_always_low_fires: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (valid_i && trig_mode_i == 4'h0 && result_i <= low_band_threshold_i) |=> trig_fire_o)
        else $error("low always mode did not fire");
    a_none_never_fires: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (int_mode_i == 4'h3) |=> !int_fire_o)
        else $error("none mode fired");
endmodule

// File: design/adc_compare_average_phase_ctrl.sv
// Top: register port, averaging, comparators, sequence interrupts and phase delay
`timescale 1ns/10ps
module adc_compare_average_phase_ctrl
    import adc_cap_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic trigger_i,
    input wire logic [1:0] trigger_seq_i,
    output logic start_o,
    output logic [1:0] start_seq_o,
    input wire logic conv_valid_i,
    input wire logic [RES_W-1:0] conv_result_i,
    input wire logic [1:0] conv_seq_i,
    input wire logic [2:0] conv_cmp_i,
    input wire logic conv_to_cmp_i,
    input wire logic conv_step_end_i,
    output logic push_o,
    output logic [RES_W-1:0] push_data_o,
    output logic [1:0] push_seq_o,
    output logic [NUM_CMP-1:0] cmp_trig_o,
    output logic [NUM_SEQ-1:0] seq_irq_o
);
    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [NUM_SEQ-1:0] seq_raw_q, seq_raw_d, seq_en_q, seq_en_d;
    logic [NUM_SEQ-1:0] cmp_seq_en_q, cmp_seq_en_d, cmp_seq_raw_q, cmp_seq_raw_d;
    logic [NUM_CMP-1:0] cmp_stat_q, cmp_stat_d;
    logic [2:0] average_factor_q, average_factor_d;
    logic [3:0] start_phase_select_q, start_phase_select_d;
    logic [31:0] cmp_cfg_q [NUM_CMP];
    logic [31:0] cmp_cfg_d [NUM_CMP];
    logic [31:0] cmp_band_q [NUM_CMP];
    logic [31:0] cmp_band_d [NUM_CMP];
    logic [31:0] rdata_d;
    logic [NUM_CMP-1:0] clr_trig_hist, clr_int_hist, cmp_int_fire, cmp_valid;
    logic avg_done;
    logic [RES_W-1:0] avg_value;
    logic [2:0] widx;
    logic in_cfg, in_band;

    assign widx = addr_i[4:2];
    assign in_cfg = (addr_i[7:5] == REG_CMP_CFG[7:5]);
    assign in_band = (addr_i[7:5] == REG_CMP_BAND[7:5]);

    // ---------------------------------------------------------------
    // Averaging accumulator
    // ---------------------------------------------------------------
    logic [RES_W+5:0] acc_q, acc_d;
    logic [5:0] cnt_q, cnt_d;
    logic [5:0] last_cnt;

    always_comb begin
        last_cnt = 6'((7'h01 << average_factor_q) - 7'h01);
        acc_d = acc_q;
        cnt_d = cnt_q;
        avg_done = 1'b0;
        avg_value = conv_result_i;
        if (conv_valid_i) begin
            if (average_factor_q == 3'h0) begin
                avg_done = 1'b1;
            end else if (cnt_q == last_cnt) begin
                avg_value = RES_W'((acc_q + (RES_W+6)'(conv_result_i)) >> average_factor_q);
                avg_done = 1'b1;
                acc_d = '0;
                cnt_d = '0;
            end else begin
                acc_d = acc_q + (RES_W+6)'(conv_result_i);
                cnt_d = cnt_q + 6'h01;
            end
        end
        if (wr_i && addr_i == REG_AVG) begin
            acc_d = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= '0;
            cnt_q <= '0;
            push_o <= 1'b0;
            push_data_o <= '0;
            push_seq_o <= '0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            push_o <= avg_done;
            push_data_o <= avg_value;
            push_seq_o <= conv_seq_i;
        end
    end

    // ---------------------------------------------------------------
    // Comparators
    // ---------------------------------------------------------------
    for (genvar c = 0; c < NUM_CMP; c++) begin : g_cmp
        assign cmp_valid[c] = avg_done && conv_to_cmp_i && (conv_cmp_i == 3'(c));
        adc_cmp_unit u_cmp (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .valid_i(cmp_valid[c]),
            .result_i(avg_value),
            .low_band_threshold_i(cmp_band_q[c][BAND_LOW_LSB +: RES_W]),
            .high_band_threshold_i(cmp_band_q[c][BAND_HIGH_LSB +: RES_W]),
            .trig_mode_i(cmp_cfg_q[c][CFG_TRIG_LSB +: CFG_W]),
            .int_mode_i(cmp_cfg_q[c][CFG_INT_LSB +: CFG_W]),
            .clear_trigger_history_i(clr_trig_hist[c]),
            .clear_interrupt_history_i(clr_int_hist[c]),
            .trig_fire_o(cmp_trig_o[c]),
            .int_fire_o(cmp_int_fire[c])
        );
    end

    // Register conv_seq_i every cycle so it lines up with the comparator fire outputs one cycle later
    logic [1:0] cmp_seq_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_seq_q <= '0;
        end else begin
            cmp_seq_q <= conv_seq_i;
        end
    end

    // ---------------------------------------------------------------
    // Register writes and status
    // ---------------------------------------------------------------
    always_comb begin
        seq_raw_d = seq_raw_q;
        seq_en_d = seq_en_q;
        cmp_seq_en_d = cmp_seq_en_q;
        cmp_seq_raw_d = cmp_seq_raw_q;
        cmp_stat_d = cmp_stat_q;
        average_factor_d = average_factor_q;
        start_phase_select_d = start_phase_select_q;
        cmp_cfg_d = cmp_cfg_q;
        cmp_band_d = cmp_band_q;
        clr_trig_hist = '0;
        clr_int_hist = '0;
        if (wr_i) begin
            unique case (addr_i)
                REG_SEQ_MASK: begin
                    // Newly enabled sequences drop any stale pending request
                    seq_raw_d = seq_raw_q & ~(wdata_i[NUM_SEQ-1:0] & ~seq_en_q);
                    seq_en_d = wdata_i[NUM_SEQ-1:0];
                end
                REG_SEQ_CLR: begin
                    seq_raw_d = seq_raw_q & ~wdata_i[NUM_SEQ-1:0];
                    cmp_seq_raw_d = cmp_seq_raw_q & ~wdata_i[2*NUM_SEQ-1:NUM_SEQ];
                end
                REG_CMP_STAT: cmp_stat_d = cmp_stat_q & ~wdata_i[NUM_CMP-1:0];
                REG_CMP_SEQEN: cmp_seq_en_d = wdata_i[NUM_SEQ-1:0];
                REG_AVG: begin
                    average_factor_d = (wdata_i[2:0] > AVG_MAX) ? AVG_MAX : wdata_i[2:0];
                end
                REG_PHASE: start_phase_select_d = wdata_i[3:0];
                REG_CMP_RESET: begin
                    clr_trig_hist = wdata_i[NUM_CMP-1:0];
                    clr_int_hist = wdata_i[RST_INT_LSB +: NUM_CMP];
                end
                default: begin
                    if (in_cfg) begin
                        cmp_cfg_d[widx] = wdata_i;
                    end else if (in_band) begin
                        cmp_band_d[widx] = wdata_i;
                    end
                end
            endcase
        end
        // Hardware sets win over software clears
        if (push_o && conv_step_end_i) begin
            seq_raw_d[push_seq_o] = 1'b1;
        end
        cmp_stat_d = cmp_stat_d | cmp_int_fire;
        if (|cmp_int_fire && cmp_seq_en_q[cmp_seq_q]) begin
            cmp_seq_raw_d[cmp_seq_q] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_raw_q <= '0;
            seq_en_q <= '0;
            cmp_seq_en_q <= '0;
            cmp_seq_raw_q <= '0;
            cmp_stat_q <= '0;
            average_factor_q <= '0;
            start_phase_select_q <= PHASE_RESET;
            for (int i = 0; i < NUM_CMP; i++) begin
                cmp_cfg_q[i] <= CFG_RESET;
                cmp_band_q[i] <= BAND_RESET;
            end
        end else begin
            seq_raw_q <= seq_raw_d;
            seq_en_q <= seq_en_d;
            cmp_seq_en_q <= cmp_seq_en_d;
            cmp_seq_raw_q <= cmp_seq_raw_d;
            cmp_stat_q <= cmp_stat_d;
            average_factor_q <= average_factor_d;
            start_phase_select_q <= start_phase_select_d;
            cmp_cfg_q <= cmp_cfg_d;
            cmp_band_q <= cmp_band_d;
        end
    end

    assign seq_irq_o = seq_raw_q & seq_en_q;

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        if (rd_i) begin
            unique case (addr_i)
                REG_SEQ_RAW: rdata_d = 32'({cmp_seq_raw_q, seq_raw_q});
                REG_SEQ_MASK: rdata_d = 32'(seq_en_q);
                REG_SEQ_STAT: begin
                    rdata_d = 32'({cmp_seq_raw_q & cmp_seq_en_q, seq_raw_q & seq_en_q});
                end
                REG_CMP_STAT: rdata_d = 32'(cmp_stat_q);
                REG_CMP_SEQEN: rdata_d = 32'(cmp_seq_en_q);
                REG_AVG: rdata_d = 32'(average_factor_q);
                REG_PHASE: rdata_d = 32'(start_phase_select_q);
                default: begin
                    if (in_cfg) begin
                        rdata_d = cmp_cfg_q[widx];
                    end else if (in_band) begin
                        rdata_d = cmp_band_q[widx];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // Phase delay between trigger and sequence start
    // ---------------------------------------------------------------
    typedef enum logic {PH_IDLE, PH_WAIT} ph_state_t;
    ph_state_t ph_q, ph_d;
    logic [11:0] ph_cnt_q, ph_cnt_d;
    logic [1:0] ph_seq_q, ph_seq_d;
    logic start_d;

    always_comb begin
        ph_d = ph_q;
        ph_cnt_d = ph_cnt_q;
        ph_seq_d = ph_seq_q;
        start_d = 1'b0;
        unique case (ph_q)
            PH_IDLE: begin
                if (trigger_i) begin
                    ph_seq_d = trigger_seq_i;
                    // One setting for the whole module, step = period / 16
                    ph_cnt_d = 12'(start_phase_select_q * PHASE_STEP_CYCLES);
                    if (start_phase_select_q == 4'h0) begin
                        start_d = 1'b1;
                    end else begin
                        ph_d = PH_WAIT;
                    end
                end
            end
            PH_WAIT: begin
                ph_cnt_d = ph_cnt_q - 12'h001;
                if (ph_cnt_q == 12'h001) begin
                    start_d = 1'b1;
                    ph_d = PH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_q <= PH_IDLE;
            ph_cnt_q <= '0;
            ph_seq_q <= '0;
            start_o <= 1'b0;
            start_seq_o <= '0;
        end else begin
            ph_q <= ph_d;
            ph_cnt_q <= ph_cnt_d;
            ph_seq_q <= ph_seq_d;
            start_o <= start_d;
            start_seq_o <= ph_seq_d;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_zero_phase_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ph_q == PH_IDLE && trigger_i && start_phase_select_q == 4'h0) |=> start_o)
        else $error("zero phase start not immediate");
    a_phase_one_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ph_q == PH_IDLE && trigger_i && start_phase_select_q == 4'h1)
        |=> !start_o [*8] ##0 (ph_q == PH_WAIT) ##1 start_o)
        else $error("phase step too short");
    a_clear_drops_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && addr_i == REG_SEQ_CLR && wdata_i[0] && !(push_o && conv_step_end_i))
        |=> !seq_irq_o[0])
        else $error("clear did not drop request");
    a_enable_clears_pend: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_i && addr_i == REG_SEQ_MASK && wdata_i[1] && !seq_en_q[1]
         && !(push_o && conv_step_end_i)) |=> !seq_raw_q[1])
        else $error("enable left stale pending");
    a_masked_view: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == REG_SEQ_STAT) |=> rdata_o[NUM_SEQ-1:0] == $past(seq_irq_o))
        else $error("masked view mismatch");
    a_no_avg_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (conv_valid_i && average_factor_q == 3'h0) |=> (push_o && push_data_o == $past(conv_result_i)))
        else $error("unaveraged result not passed");
    a_avg_two_push: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (conv_valid_i && average_factor_q == 3'h1 && cnt_q == 6'h00 && !wr_i) |=> !push_o)
        else $error("partial average pushed");
    a_cmp_stat_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cmp_int_fire[0]) |=> cmp_stat_q[0])
        else $error("comparator status not set");

    c_phase_wait: cover property (@(posedge clk_i) disable iff (!rst_n_i) ph_q == PH_WAIT ##1 start_o);
    c_avg_push: cover property (@(posedge clk_i) disable iff (!rst_n_i) push_o && average_factor_q == 3'h2);
    c_cmp_fire: cover property (@(posedge clk_i) disable iff (!rst_n_i) |cmp_trig_o);
    c_seq_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) |seq_irq_o);
endmodule

// File: test/conv_core_model.sv
// Conversion core model: emits a burst of consecutive results of one input
`timescale 1ns/10ps
module conv_core_model
    import adc_cap_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic [6:0] count_i,
    input wire logic [RES_W-1:0] base_i,
    output logic conv_valid_o,
    output logic [RES_W-1:0] conv_result_o
);
    logic [6:0] left_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_q <= '0;
            conv_valid_o <= 1'b0;
            conv_result_o <= '0;
        end else if (go_i) begin
            left_q <= count_i;
            conv_result_o <= base_i - 12'h001;
        end else if (left_q != 7'h00) begin
            left_q <= left_q - 7'h01;
            conv_valid_o <= 1'b1;
            conv_result_o <= conv_result_o + 12'h001;
        end else begin
            // Idle data lines do not hold the last sample
            conv_valid_o <= 1'b0;
            conv_result_o <= ~conv_result_o;
        end
    end
endmodule

// File: test/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module testbench
    import adc_cap_pkg::*;
;
    logic clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, trig = 0, go = 0, cv, ps, st;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata, v;
    logic [1:0] tseq = 2, seq = 0, pseq, sseq;
    logic [6:0] cnt = 0;
    logic [11:0] base = 0, cr, pd;
    logic [7:0] ctrig;
    logic [3:0] irq;
    logic tg;
    logic [1:0] ls;
    int miscompares = 0, compares = 0, n, k;
    logic [7:0] ra[6] = '{8'h18, 8'h1C, 8'h40, 8'h60, 8'h04, 8'hFC};
    logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h33, 32'h0FFF_0000, 32'h0, 32'h0};
    logic [11:0] cres[4] = '{12'h100, 12'h101, 12'h200, 12'h201};
    logic cexp[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [11:0] hres[4] = '{12'h050, 12'h300, 12'h050, 12'h050};
    logic hexp[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [3:0] phs[4] = '{4'h0, 4'h1, 4'h8, 4'hF};
    always #4 clk_i = ~clk_i;
    adc_compare_average_phase_ctrl u_adc_compare_average_phase_ctrl (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .trigger_i(trig), .trigger_seq_i(tseq), .start_o(st),
        .start_seq_o(sseq), .conv_valid_i(cv), .conv_result_i(cr), .conv_seq_i(seq),
        .conv_cmp_i(3'h0), .conv_to_cmp_i(1'b1), .conv_step_end_i(1'b1), .push_o(ps),
        .push_data_o(pd), .push_seq_o(pseq), .cmp_trig_o(ctrig), .seq_irq_o(irq));
    conv_core_model u_conv_core_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go),
        .count_i(cnt), .base_i(base), .conv_valid_o(cv), .conv_result_o(cr));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a; wdata <= d; wr <= 1;
        @(posedge clk_i);
        wr <= 0;
    endtask
    task rreg(input logic [7:0] a);
        @(posedge clk_i);
        addr <= a; rd <= 1;
        @(posedge clk_i);
        rd <= 0;
        #1 v = rdata;
    endtask
    // Runs 2^f conversions from base b on sequence s, records push data and trigger
    task conv(input int f, input logic [11:0] b, input logic [1:0] s);
        @(posedge clk_i);
        seq <= s; go <= 1; cnt <= 7'(1 << f); base <= b;
        @(posedge clk_i);
        go <= 0; tg = 0; v = 'x; ls = 'x;
        repeat (140) begin
            @(posedge clk_i);
            #1 tg |= ctrig[0];
            if (ps === 1'b1) begin
                v = 32'(pd);
                ls = pseq;
            end
        end
    endtask
    initial begin
        #400000 miscompares++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1;
        for (int i = 0; i < 6; i++) begin rreg(ra[i]); chk("reset reg", v, rv[i]); end
        $display("reset values done");
        // ----------------------------------------
        // Averaging factors and band edges
        // ----------------------------------------
        for (int f = 0; f <= 6; f++) begin
            wreg(REG_AVG, 32'(f));
            conv(f, 12'h7C1, 0);
            n = 1 << f;
            chk("average", v, 32'((n * 'h7C1 + n * (n - 1) / 2) >> f));
        end
        wreg(REG_AVG, 32'h7);
        rreg(REG_AVG);
        chk("factor saturation", v, 32'h6);
        wreg(REG_AVG, 32'h0);
        wreg(REG_CMP_BAND, 32'h0200_0100);
        wreg(REG_CMP_CFG, 32'h31);
        for (int i = 0; i < 4; i++) begin conv(0, cres[i], 0); chk("band", tg, cexp[i]); end
        wreg(REG_CMP_CFG, 32'h15);
        conv(0, 12'h150, 0);
        chk("once entry", tg, 1);
        conv(0, 12'h150, 0);
        chk("once repeat", tg, 0);
        wreg(REG_CMP_RESET, 32'h1);
        conv(0, 12'h150, 0);
        chk("history clear", tg, 1);
        rreg(REG_CMP_STAT);
        chk("cmp status", v & 32'h1, 1);
        wreg(REG_CMP_CFG, 32'h38);
        for (int i = 0; i < 4; i++) begin
            conv(0, hres[i], 0);
            chk("hysteresis", tg, hexp[i]);
        end
        wreg(REG_CMP_CFG, 32'h30);
        conv(0, 12'h050, 0);
        chk("low always", tg, 1);
        $display("averaging and comparator done");
        // ----------------------------------------
        // Sequence interrupts and phase delay
        // ----------------------------------------
        conv(0, 12'h5, 1);
        chk("push seq", ls, 2'h1);
        rreg(REG_SEQ_RAW);
        chk("raw status", v & 32'h2, 2);
        wreg(REG_SEQ_MASK, 32'h2);
        rreg(REG_SEQ_RAW);
        chk("enable clears", v & 32'h2, 0);
        conv(0, 12'h5, 1);
        chk("irq line", irq, 4'h2);
        rreg(REG_SEQ_STAT);
        chk("masked status", v & 32'hF, 2);
        wreg(REG_SEQ_CLR, 32'h2);
        #1 chk("irq cleared", irq, 4'h0);
        foreach (phs[p]) begin
            wreg(REG_PHASE, 32'(phs[p]));
            @(posedge clk_i);
            trig <= 1;
            @(posedge clk_i);
            trig <= 0;
            k = 1;
            #1;
            while (st !== 1'b1 && k < 200) begin
                k++;
                @(posedge clk_i);
                #1;
            end
            chk("phase delay", k, phs[p] * PHASE_STEP_CYCLES + 1);
            chk("start seq", sseq, 2);
        end
        $display("interrupts and phase done");
        rst_n_i <= 0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1;
        rreg(REG_PHASE);
        chk("phase after reset", v, 32'(PHASE_RESET));
        $display("reset rerun done");
        test_done();
    end
endmodule
